/* sesi_consts.svh */
`ifndef SESI_CONSTS_SVH
`define SESI_CONSTS_SVH

// Core clock period and the longest self-timed programming time.
`define SESI_CORE_CLK_NS   100
`define SESI_NS_PER_MS     1000000
`define SESI_TWR_MS        5
`define SESI_TIMER_W       16
`define SESI_TIMER_STEP    16'h0001

// Bit counting within one byte; bytes travel most significant bit first.
`define SESI_BIT_FIRST     3'h0
`define SESI_BIT_LAST      3'h7
`define SESI_BIT_MSB       7

// Control byte layout.
`define SESI_CTRL_CODE_HI  7
`define SESI_CTRL_CODE_LO  4
`define SESI_CTRL_SEL_HI   3
`define SESI_CTRL_SEL_LO   1
`define SESI_CTRL_RW       0
`define SESI_RW_READ       1'b1

// Address pointer split into page number and position within the page.
`define SESI_PAGE_HI       7
`define SESI_PAGE_LO       3
`define SESI_POS_HI        2
`define SESI_POS_LO        0
`define SESI_POS_STEP      3'h1
`define SESI_PTR_STEP      8'h01
`define SESI_PAGE_BYTES    8
`define SESI_MEM_WORDS     256

`endif

/* sesi_pkg.sv */
package sesi_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_ctrl,
      st_waddr,
      st_wdata,
      st_rdata,
      st_skip
   } sesi_state_t;

   // State of the logic that runs on the link clock.
   typedef struct packed {
      logic             scl_s1;
      logic             scl_s2;
      logic             scl_s3;
      logic             sda_s1;
      logic             sda_s2;
      logic             sda_s3;
      logic             wp_s1;
      logic             wp_s2;
      logic [2:0]       sel_s1;
      logic [2:0]       sel_s2;
      logic             done_s1;
      logic             done_s2;
      logic             done_s3;
      sesi_state_t      state;
      sesi_state_t      after_ack;
      logic [2:0]       bit_cnt;
      logic             byte_full;
      logic             ack_phase;
      logic             master_ack;
      logic [7:0]       shift;
      logic [7:0]       ptr;
      logic [7:0][7:0]  page;
      logic [7:0]       page_valid;
      logic [4:0]       page_base;
      logic             commit;
      logic             req_tgl;
      logic             busy;
      logic             sda_oe;
      logic             sda_out;
   } sesi_link_t;

   // State of the write-cycle timer on the core clock.
   typedef struct packed {
      logic             req_s1;
      logic             req_s2;
      logic             req_s3;
      logic             busy;
      logic [15:0]      cnt;
      logic             done_tgl;
   } sesi_core_t;

endpackage

/* sesi_eeprom.sv */
// Operation
// R01: SDA falling while SCL high is a START; every command begins with one.
// R02: SDA rising while SCL high is a STOP; every operation ends with one.
// R03: Data changes only while SCL low; changes during SCL high are START or STOP.
// R04: One clock pulse per bit; value sampled during SCL high is the bit.
// R05: Master starts a transfer only when both lines are high.
// R06: Ninth clock per byte; receiver holds SDA low through its high phase.
// R07: No byte is acknowledged while a programming cycle runs.
// R08: Master withholds ack on last read byte; device then releases SDA.
// R09: Control byte holds device code, three select bits, then read/write bit.
// R10: Select bits match select pins, or are ignored in the single-device variant.
// R11: Control byte acknowledged only on address match and when not programming.
// R12: Write: word address loads the pointer and is acked, data byte is acked.
// R13: STOP after write data starts the timed write cycle; no acks meanwhile.
// R14: Up to eight data bytes gather in a page buffer, committed after STOP.
// R15: Each written byte increments only the low three pointer bits.
// R16: More than eight bytes wrap the page position and overwrite earlier ones.
// R17: Master polls busy with START and write control byte; ack means done.
// R18: Write-protect high inhibits all programming; reads still work.
// R19: Pointer holds last accessed address plus one for current-address reads.
// R20: Matched read control byte is acked and one data byte shifted out.
// R21: Repeated START after word address aborts the write but keeps the pointer.
// R22: Master ack after a read byte makes the device send the next address.
// R23: Write-protect defaults to unprotected when left unconnected; here wp_in has no default and must be tied low.
// R24: All bytes travel most significant bit first.
// R25: Pointer is eight bits; read increments wrap from top to zero.
// R26: Write-cycle time is a parameter counted by a timer holding busy.
`timescale 1ns/1ns
`include "sesi_consts.svh"

module sesi_eeprom #(
   parameter logic        ADDR_PINS_USED = 1'b1,
   // Device-type code is an arbitrary value.
   parameter logic [3:0]  DEV_TYPE_CODE  = 4'hB,
   parameter logic [15:0] WRITE_CYCLES   = 16'(`SESI_TWR_MS * `SESI_NS_PER_MS / `SESI_CORE_CLK_NS)
) (
   // Clocks and reset.
   input  wire logic core_clk,
   input  wire logic link_clk,
   input  wire logic sys_rst,
   // Two-wire bus pins.
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   // Straps.
   input  wire logic wp_in,
   input  wire logic select_pin_0,
   input  wire logic select_pin_1,
   input  wire logic select_pin_2,
   // Status.
   output logic      write_busy
);

   // The SCL and SDA sync stages reset high, like an idle bus, so no false edge follows reset.
   localparam sesi_pkg::sesi_link_t LINK_RESET = '{
      scl_s1    : 1'b1,
      scl_s2    : 1'b1,
      scl_s3    : 1'b1,
      sda_s1    : 1'b1,
      sda_s2    : 1'b1,
      sda_s3    : 1'b1,
      state     : sesi_pkg::st_idle,
      after_ack : sesi_pkg::st_idle,
      default   : '0
   };

   localparam sesi_pkg::sesi_core_t CORE_RESET = '0;

   sesi_pkg::sesi_link_t link_reg;
   sesi_pkg::sesi_link_t link_next;
   sesi_pkg::sesi_core_t core_reg;
   sesi_pkg::sesi_core_t core_next;

   // The array has no reset; its contents are unknown until written.
   logic [7:0] mem [0:`SESI_MEM_WORDS-1];
   logic [7:0] rd_byte;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;
   logic       done_edge;
   logic       addr_match;
   logic       code_ok;
   logic       sel_ok;

   // Edge and condition detection looks only at the second and third stages.
   assign scl_rise   = link_reg.scl_s2 & ~link_reg.scl_s3;
   assign scl_fall   = ~link_reg.scl_s2 & link_reg.scl_s3;
   assign start_seen = link_reg.scl_s2 & link_reg.scl_s3 & link_reg.sda_s3 & ~link_reg.sda_s2; // R01 R03
   assign stop_seen  = link_reg.scl_s2 & link_reg.scl_s3 & ~link_reg.sda_s3 & link_reg.sda_s2; // R02 R03
   assign done_edge  = link_reg.done_s2 ^ link_reg.done_s3;

   assign code_ok    = link_reg.shift[`SESI_CTRL_CODE_HI:`SESI_CTRL_CODE_LO] == DEV_TYPE_CODE; // R09
   // The single-device variant ignores the select bits altogether.
   assign sel_ok     = !ADDR_PINS_USED
                       || link_reg.shift[`SESI_CTRL_SEL_HI:`SESI_CTRL_SEL_LO] == link_reg.sel_s2; // R10
   assign addr_match = code_ok & sel_ok;

   // The array is read without a clock so the next byte is ready at the falling edge.
   assign rd_byte    = mem[link_reg.ptr];

   // Link domain: protocol engine, pointer and page buffer.
   always_comb
   begin
      link_next = link_reg;
      link_next.scl_s1  = scl_in;
      link_next.scl_s2  = link_reg.scl_s1;
      link_next.scl_s3  = link_reg.scl_s2;
      link_next.sda_s1  = sda_in;
      link_next.sda_s2  = link_reg.sda_s1;
      link_next.sda_s3  = link_reg.sda_s2;
      // An unconnected protect pin must be tied low, which leaves writes enabled.
      link_next.wp_s1   = wp_in; // R23
      link_next.wp_s2   = link_reg.wp_s1;
      link_next.sel_s1  = {select_pin_2, select_pin_1, select_pin_0};
      link_next.sel_s2  = link_reg.sel_s1;
      // Requests and completions cross between the clocks as toggles through three stages.
      link_next.done_s1 = core_reg.done_tgl;
      link_next.done_s2 = link_reg.done_s1;
      link_next.done_s3 = link_reg.done_s2;
      // Commit is a pulse of one link cycle.
      link_next.commit  = 1'b0;
      link_next.sda_out = 1'b0;

      if (done_edge)
      begin
         link_next.busy = 1'b0; // R26
      end

      if (start_seen)
      begin
         // A repeated start drops gathered data but keeps the pointer.
         link_next.state      = sesi_pkg::st_ctrl; // R21
         link_next.bit_cnt    = `SESI_BIT_FIRST;
         link_next.byte_full  = 1'b0;
         link_next.ack_phase  = 1'b0;
         link_next.sda_oe     = 1'b0;
         link_next.page_valid = '0;
      end
      else if (stop_seen)
      begin
         // Protected or empty writes end quietly, with neither commit nor busy.
         if (link_reg.state == sesi_pkg::st_wdata && |link_reg.page_valid && !link_reg.wp_s2) // R13 R18
         begin
            link_next.commit  = 1'b1; // R14
            link_next.busy    = 1'b1; // R13
            link_next.req_tgl = ~link_reg.req_tgl;
         end
         link_next.state     = sesi_pkg::st_idle;
         link_next.ack_phase = 1'b0;
         link_next.byte_full = 1'b0;
         link_next.sda_oe    = 1'b0;
      end
      else if (scl_rise)
      begin
         if (link_reg.ack_phase)
         begin
            if (link_reg.state == sesi_pkg::st_rdata)
            begin
               // A low line in the acknowledge slot asks for the next byte.
               link_next.master_ack = ~link_reg.sda_s2; // R22
            end
         end
         else if (link_reg.state != sesi_pkg::st_idle && link_reg.state != sesi_pkg::st_skip)
         begin
            if (link_reg.state != sesi_pkg::st_rdata)
            begin
               link_next.shift = {link_reg.shift[`SESI_BIT_MSB-1:0], link_reg.sda_s2}; // R04 R24
            end
            if (link_reg.bit_cnt == `SESI_BIT_LAST)
            begin
               link_next.byte_full = 1'b1;
            end
            else
            begin
               link_next.bit_cnt = link_reg.bit_cnt + `SESI_POS_STEP;
            end
         end
      end
      else if (scl_fall)
      begin
         if (link_reg.ack_phase)
         begin
            link_next.ack_phase = 1'b0;
            link_next.sda_oe    = 1'b0; // R06
            case (link_reg.state)
               sesi_pkg::st_rdata:
               begin
                  if (link_reg.master_ack)
                  begin
                     link_next.shift  = rd_byte; // R22
                     link_next.ptr    = link_reg.ptr + `SESI_PTR_STEP; // R25
                     link_next.sda_oe = ~rd_byte[`SESI_BIT_MSB];
                  end
                  else
                  begin
                     link_next.state = sesi_pkg::st_skip; // R08
                  end
               end
               default:
               begin
                  link_next.state = link_reg.after_ack;
                  if (link_reg.after_ack == sesi_pkg::st_rdata)
                  begin
                     link_next.shift  = rd_byte; // R19 R20
                     link_next.ptr    = link_reg.ptr + `SESI_PTR_STEP; // R25
                     link_next.sda_oe = ~rd_byte[`SESI_BIT_MSB]; // R24
                  end
               end
            endcase
         end
         else if (link_reg.byte_full)
         begin
            link_next.byte_full = 1'b0;
            link_next.bit_cnt   = `SESI_BIT_FIRST;
            case (link_reg.state)
               sesi_pkg::st_ctrl:
               begin
                  // A busy device stays silent even to its own address, which polling relies on.
                  if (addr_match && !link_reg.busy) // R11 R07 R17
                  begin
                     link_next.ack_phase = 1'b1;
                     link_next.sda_oe    = 1'b1; // R06
                     if (link_reg.shift[`SESI_CTRL_RW] == `SESI_RW_READ) // R09
                     begin
                        link_next.after_ack = sesi_pkg::st_rdata; // R20
                     end
                     else
                     begin
                        link_next.after_ack = sesi_pkg::st_waddr;
                     end
                  end
                  else
                  begin
                     link_next.state = sesi_pkg::st_skip;
                  end
               end
               sesi_pkg::st_waddr:
               begin
                  if (!link_reg.busy) // R07
                  begin
                     // The pointer is set at once, so a repeated start can read from it.
                     link_next.ptr       = link_reg.shift; // R12
                     link_next.page_base = link_reg.shift[`SESI_PAGE_HI:`SESI_PAGE_LO];
                     link_next.ack_phase = 1'b1;
                     link_next.sda_oe    = 1'b1;
                     link_next.after_ack = sesi_pkg::st_wdata;
                  end
                  else
                  begin
                     link_next.state = sesi_pkg::st_skip;
                  end
               end
               sesi_pkg::st_wdata:
               begin
                  if (!link_reg.busy) // R07
                  begin
                     // Position wraps inside the page, so later bytes overwrite earlier ones.
                     link_next.page[link_reg.ptr[`SESI_POS_HI:`SESI_POS_LO]]       = link_reg.shift; // R14 R16
                     link_next.page_valid[link_reg.ptr[`SESI_POS_HI:`SESI_POS_LO]] = 1'b1;
                     link_next.ptr[`SESI_POS_HI:`SESI_POS_LO] =
                        link_reg.ptr[`SESI_POS_HI:`SESI_POS_LO] + `SESI_POS_STEP; // R15 R19
                     link_next.ack_phase = 1'b1;
                     link_next.sda_oe    = 1'b1; // R12
                     link_next.after_ack = sesi_pkg::st_wdata;
                  end
                  else
                  begin
                     link_next.state = sesi_pkg::st_skip;
                  end
               end
               sesi_pkg::st_rdata:
               begin
                  // Release the line so the master can answer.
                  link_next.ack_phase  = 1'b1;
                  link_next.sda_oe     = 1'b0; // R08
                  link_next.master_ack = 1'b0;
               end
               default:
               begin
                  link_next.state = sesi_pkg::st_skip;
               end
            endcase
         end
         else if (link_reg.state == sesi_pkg::st_rdata)
         begin
            // The next bit goes out after the falling edge, so the line never moves while the clock is high.
            link_next.shift  = {link_reg.shift[`SESI_BIT_MSB-1:0], 1'b0}; // R24
            link_next.sda_oe = ~link_reg.shift[`SESI_BIT_MSB-1]; // R03
         end
      end

      // Clearing after the commit leaves the buffer empty for the next write.
      if (link_reg.commit)
      begin
         link_next.page_valid = '0;
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         link_reg <= LINK_RESET;
      end
      else
      begin
         link_reg <= link_next;
      end
   end

   // Page commit into the array, one cycle after the stop is seen.
   always_ff @(posedge link_clk)
   begin
      if (link_reg.commit)
      begin
         for (int i = 0; i < `SESI_PAGE_BYTES; i++)
         begin
            if (link_reg.page_valid[i])
            begin
               mem[{link_reg.page_base, 3'(i)}] <= link_reg.page[i]; // R14
            end
         end
      end
   end

   // Core domain: self-timed write cycle.
   always_comb
   begin
      core_next = core_reg;
      core_next.req_s1 = link_reg.req_tgl;
      core_next.req_s2 = core_reg.req_s1;
      core_next.req_s3 = core_reg.req_s2;
      // A request restarts the count; none arrives while busy, as acknowledges are withheld.
      if (core_reg.req_s2 ^ core_reg.req_s3)
      begin
         core_next.busy = 1'b1; // R26
         core_next.cnt  = '0;
      end
      else if (core_reg.busy)
      begin
         // Busy ends after exactly the set number of core cycles.
         if (core_reg.cnt >= WRITE_CYCLES - `SESI_TIMER_STEP)
         begin
            core_next.busy     = 1'b0; // R26
            core_next.done_tgl = ~core_reg.done_tgl;
         end
         else
         begin
            core_next.cnt = core_reg.cnt + `SESI_TIMER_STEP;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         core_reg <= CORE_RESET;
      end
      else
      begin
         core_reg <= core_next;
      end
   end

   // Every output comes straight from a register.
   assign sda_out    = link_reg.sda_out;
   assign sda_oe     = link_reg.sda_oe;
   assign write_busy = core_reg.busy;

endmodule

/* sesi_props.sv */
`timescale 1ns/1ns
module sesi_props #(
   parameter logic [15:0] WRITE_CYCLES = 16'h0014
) (
   // Clocks and reset.
   input wire logic core_clk,
   input wire logic link_clk,
   input wire logic sys_rst,
   // Bus pins and straps.
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic wp_in,
   input wire logic select_pin_0,
   input wire logic select_pin_1,
   input wire logic select_pin_2,
   // Status.
   input wire logic write_busy
);
   logic [15:0] busy_cnt_reg;

   // Counts core cycles of the current busy period.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         busy_cnt_reg <= 16'h0000;
      else
         busy_cnt_reg <= write_busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
   end

   out_low_a: assert property (@(posedge link_clk) disable iff (sys_rst) !sda_out)
      else $error("data drive value not low");
   busy_noack_a: assert property (@(posedge core_clk) disable iff (sys_rst) write_busy |-> !sda_oe)
      else $error("bus driven during write cycle");
   busy_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(write_busy) |-> busy_cnt_reg >= WRITE_CYCLES && busy_cnt_reg <= WRITE_CYCLES + 16'h0001)
      else $error("write cycle length wrong");
   busy_max_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      busy_cnt_reg <= WRITE_CYCLES + 16'h0001)
      else $error("write cycle overran");
   wp_block_a: assert property (@(posedge core_clk) disable iff (sys_rst) $rose(write_busy) |-> !wp_in)
      else $error("write cycle while protected");
   busy_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(write_busy) |-> scl_in && sda_in)
      else $error("write cycle without bus stop");
   busy_gap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(write_busy) |=> !write_busy [*8])
      else $error("write cycle restarted");
   oe_sclow_a: assert property (@(posedge link_clk) disable iff (sys_rst) $changed(sda_oe) |-> !scl_in)
      else $error("data changed while clock high");
   rst_quiet_a: assert property (@(posedge core_clk) sys_rst |-> !write_busy && !sda_oe)
      else $error("outputs active in reset");

   cover property (@(posedge core_clk) disable iff (sys_rst) $rose(write_busy));
   cover property (@(posedge link_clk) disable iff (sys_rst) sda_oe && scl_in);
   cover property (@(posedge link_clk) disable iff (sys_rst) $fell(sda_oe));
endmodule

/* sesi_master.sv */
`timescale 1ns/1ns
module sesi_master (
   // Clock.
   input  wire logic core_clk,
   // Bus lines.
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda_low
);
   initial
   begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic pause();
      repeat (8) @(posedge core_clk);
   endtask

   // Data moves only while the clock is low.
   task automatic bit_io(input logic b, output logic r);
      sda_low <= !b;
      pause();
      scl <= 1'b1;
      pause();
      r = sda_in;
      pause();
      scl <= 1'b0;
      pause();
   endtask

   // Also serves as repeated start, entered with the clock low.
   task automatic start();
      sda_low <= 1'b0;
      pause();
      scl <= 1'b1;
      pause();
      sda_low <= 1'b1;
      pause();
      scl <= 1'b0;
      pause();
   endtask

   task automatic stop();
      sda_low <= 1'b1;
      pause();
      scl <= 1'b1;
      pause();
      sda_low <= 1'b0;
      repeat (3) pause();
   endtask

   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   task automatic recv(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
   endtask
endmodule

/* sesi_eeprom_bench.sv */
`timescale 1ns/1ns
module sesi_eeprom_bench;
   localparam logic [15:0] WCYC = 16'h0190;
   // Device-type code is arbitrary.
   localparam logic [3:0] CODE = 4'hB;
   localparam logic [2:0] SEL  = 3'h5;
   localparam logic [7:0] CW   = {CODE, SEL, 1'b0};
   localparam logic [7:0] CR   = {CODE, SEL, 1'b1};
   // Code of the single-device variant sharing the bus; the value is arbitrary.
   localparam logic [3:0] CODE_ANY = 4'h6;
   logic       core_clk = 1'b0;
   logic       link_clk = 1'b0;
   logic       sys_rst  = 1'b0;
   logic       wp_in    = 1'b0;
   logic [2:0] sel_pins = SEL;
   logic       scl;
   logic       sda_low;
   logic       sda_oe;
   logic       sda_oe_any;
   logic       sda_out;
   logic       write_busy;
   logic       ack;
   logic [7:0] q;
   logic [7:0] mem_exp [256];
   int         fail_count  = 0;
   int         checks_done = 0;
   wire        sda = !(sda_oe || sda_oe_any || sda_low);

   always #50 core_clk = !core_clk;
   always #80 link_clk = !link_clk;

   sesi_eeprom #(.ADDR_PINS_USED(1'b1), .DEV_TYPE_CODE(CODE), .WRITE_CYCLES(WCYC)) i_sesi_eeprom (
      .core_clk(core_clk), .link_clk(link_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .select_pin_0(sel_pins[0]),
      .select_pin_1(sel_pins[1]), .select_pin_2(sel_pins[2]), .write_busy(write_busy));
   sesi_eeprom #(.ADDR_PINS_USED(1'b0), .DEV_TYPE_CODE(CODE_ANY), .WRITE_CYCLES(WCYC)) i_sesi_eeprom_any (
      .core_clk(core_clk), .link_clk(link_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe_any), .wp_in(wp_in), .select_pin_0(sel_pins[0]),
      .select_pin_1(sel_pins[1]), .select_pin_2(sel_pins[2]), .write_busy());
   sesi_master i_sesi_master (.core_clk(core_clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic poll(input logic busy_exp);
      int tries;
      tries = 0;
      ack = 1'b0;
      while (!ack && tries < 8)
      begin
         i_sesi_master.start();
         i_sesi_master.send(CW, ack);
         i_sesi_master.stop();
         tries++;
      end
      chk(8'(tries), busy_exp ? 8'h02 : 8'h01);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d0, input int n, input logic prot);
      i_sesi_master.start();
      i_sesi_master.send(CW, ack);
      chk(ack, 1'b1);
      i_sesi_master.send(a, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         i_sesi_master.send(d0 + 8'(i), ack);
         chk(ack, 1'b1);
         if (!prot)
            mem_exp[{a[7:3], a[2:0] + 3'(i)}] = d0 + 8'(i);
      end
      i_sesi_master.stop();
      chk(write_busy, !prot);
      poll(!prot);
   endtask

   task automatic rd(input logic [7:0] a, input int n, input logic rand_a);
      if (rand_a)
      begin
         i_sesi_master.start();
         i_sesi_master.send(CW, ack);
         i_sesi_master.send(a, ack);
      end
      i_sesi_master.start();
      i_sesi_master.send(CR, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         i_sesi_master.recv(i < n - 1, q);
         chk(q, mem_exp[8'(a + 8'(i))]);
      end
      chk(sda, 1'b1);
      chk(sda_out, 1'b0);
      i_sesi_master.stop();
   endtask

   task automatic t_refuse();
      for (int i = 0; i < 4; i++)
      begin
         i_sesi_master.start();
         i_sesi_master.send(i < 3 ? {CODE, SEL ^ 3'(1 << i), 1'b0} : {~CODE, SEL, 1'b1}, ack);
         chk(ack, 1'b0);
         i_sesi_master.stop();
      end
   endtask

   // The single-device variant answers whatever the select bits say.
   task automatic t_single();
      for (int i = 0; i < 2; i++)
      begin
         i_sesi_master.start();
         i_sesi_master.send({CODE_ANY, i == 0 ? SEL : ~SEL, 1'b0}, ack);
         chk(ack, 1'b1);
         i_sesi_master.stop();
      end
   endtask

   // Ten bytes from position 6 of one page wrap and overwrite the two places written first, positions 6 and 7.
   task automatic t_page();
      wr(8'h3E, 8'hA0, 10, 1'b0);
      rd(8'h38, 1, 1'b0);
      rd(8'h38, 8, 1'b1);
   endtask

   task automatic t_protect();
      wr(8'h10, 8'h5A, 1, 1'b0);
      @(posedge core_clk);
      wp_in <= 1'b1;
      repeat (10) @(posedge core_clk);
      wr(8'h10, 8'hC3, 1, 1'b1);
      wp_in <= 1'b0;
      rd(8'h10, 1, 1'b1);
   endtask

   task automatic t_wrap();
      wr(8'hFF, 8'h77, 1, 1'b0);
      wr(8'h00, 8'h11, 1, 1'b0);
      rd(8'hFF, 2, 1'b1);
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      // Reset rises at time zero so the asynchronous reset sees a real edge.
      sys_rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      t_refuse();
      t_single();
      t_page();
      t_protect();
      t_wrap();
      give_verdict();
   end

   initial
   begin
      repeat (60000) @(posedge core_clk);
      fail_count++;
      give_verdict();
   end
endmodule

bind sesi_eeprom sesi_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_sesi_props (
   .core_clk(core_clk), .link_clk(link_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .select_pin_0(select_pin_0),
   .select_pin_1(select_pin_1), .select_pin_2(select_pin_2), .write_busy(write_busy));
